// ===== pkg/pmdb_cfg.svh
// How it works
// RULE1: reference-clock bit 3 set turns output off
// RULE2: reference-clock bit clear means enabled, resets zero
// RULE3: DMA channels three..zero at bits eleven..eight
// RULE4: clear DMA bit enables channel, resets zero
// RULE5: unimplemented bits always read back zero
// RULE6: bit 7 checksum off, bit 3 serial off
// RULE7: disabled peripheral clock-gated and held in reset
`ifndef PMDB_CFG_SVH
`define PMDB_CFG_SVH
`define PMDB_AW 4
`define PMDB_DW 16
`define PMDB_OFS_CRCU 4'h0
`define PMDB_OFS_REFC 4'h1
`define PMDB_OFS_DMA 4'h2
`define PMDB_BIT_CRC 7
`define PMDB_BIT_UART3 3
`define PMDB_BIT_REFO 3
`define PMDB_BIT_DMA0 8
`define PMDB_DMA_CH 4
`define PMDB_MASK_CRCU 16'h0088
`define PMDB_MASK_REFC 16'h0008
`define PMDB_MASK_DMA 16'h0F00
`define PMDB_RESET 16'h0000
// gate pair after reset: clock enabled, reset hold released
`define PMDB_GATE_RESET 2'h2
`endif

// ===== pkg/pmdb_pkg.sv
`include "pmdb_cfg.svh"
`default_nettype none
package pmdb_pkg;
    typedef logic [`PMDB_DW-1:0] pmdb_word_t;
    typedef logic [`PMDB_AW-1:0] pmdb_addr_t;
    // per-peripheral gating pair
    typedef struct packed {
        logic clkEn;
        logic rstHold;
    } pmdb_gate_s;
endpackage
`default_nettype wire

// ===== verilog/pmdb_bank.sv
`include "pmdb_cfg.svh"
`default_nettype none
module pmdb_bank (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // register port
    input wire pmdb_pkg::pmdb_addr_t addr,
    input wire pmdb_pkg::pmdb_word_t wrData,
    input wire logic wrStb,
    input wire logic rdStb,
    output var pmdb_pkg::pmdb_word_t rdData,
    // peripheral gating
    output var pmdb_pkg::pmdb_gate_s checksumGate,
    output var pmdb_pkg::pmdb_gate_s serial3Gate,
    output var pmdb_pkg::pmdb_gate_s refClkGate,
    output var pmdb_pkg::pmdb_gate_s [`PMDB_DMA_CH-1:0] dmaGate
);
    import pmdb_pkg::*;

    pmdb_word_t crcuQ, crcuD, refcQ, refcD, dmaQ, dmaD, rdQ, rdD;
    pmdb_gate_s csQ, csD, s3Q, s3D, rcQ, rcD;
    pmdb_gate_s [`PMDB_DMA_CH-1:0] dgQ, dgD;

    // register writes; masks keep unimplemented bits at zero
    always_comb begin
        crcuD = crcuQ;
        refcD = refcQ;
        dmaD = dmaQ;
        if (wrStb) begin
            // RULE6: checksum and serial bits
            if (addr == `PMDB_OFS_CRCU) crcuD = wrData & `PMDB_MASK_CRCU;
            // RULE1: reference clock bit
            if (addr == `PMDB_OFS_REFC) refcD = wrData & `PMDB_MASK_REFC;
            // RULE3: DMA channel bits
            if (addr == `PMDB_OFS_DMA) dmaD = wrData & `PMDB_MASK_DMA;
        end
    end

    // read data valid only the cycle after the strobe
    always_comb begin
        rdD = '0;
        // RULE5: unimplemented reads zero
        if (rdStb) begin
            case (addr)
                `PMDB_OFS_CRCU: rdD = crcuQ;
                `PMDB_OFS_REFC: rdD = refcQ;
                `PMDB_OFS_DMA: rdD = dmaQ;
                default: rdD = '0;
            endcase
        end
    end

    // gating registers from the next-state bits, so it changes in the same cycle as the stored bits
    // RULE7: clock off, reset held
    always_comb begin
        csD.clkEn = !crcuD[`PMDB_BIT_CRC];
        csD.rstHold = crcuD[`PMDB_BIT_CRC];
        s3D.clkEn = !crcuD[`PMDB_BIT_UART3];
        s3D.rstHold = crcuD[`PMDB_BIT_UART3];
        // RULE2: clear bit enables
        rcD.clkEn = !refcD[`PMDB_BIT_REFO];
        rcD.rstHold = refcD[`PMDB_BIT_REFO];
    end

    // RULE4: per-channel enable
    for (genvar i = 0; i < `PMDB_DMA_CH; i++) begin : g_dma
        assign dgD[i].clkEn = !dmaD[`PMDB_BIT_DMA0+i];
        assign dgD[i].rstHold = dmaD[`PMDB_BIT_DMA0+i];
    end

    // RULE2: reset clears every register bit; gates load clock enabled
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            crcuQ <= `PMDB_RESET;
            refcQ <= `PMDB_RESET;
            dmaQ <= `PMDB_RESET;
            rdQ <= '0;
            // every module starts enabled, nothing held in reset
            csQ <= `PMDB_GATE_RESET;
            s3Q <= `PMDB_GATE_RESET;
            rcQ <= `PMDB_GATE_RESET;
            dgQ <= {`PMDB_DMA_CH{`PMDB_GATE_RESET}};
        end else begin
            crcuQ <= crcuD;
            refcQ <= refcD;
            dmaQ <= dmaD;
            rdQ <= rdD;
            csQ <= csD;
            s3Q <= s3D;
            rcQ <= rcD;
            dgQ <= dgD;
        end
    end

    assign rdData = rdQ;
    assign checksumGate = csQ;
    assign serial3Gate = s3Q;
    assign refClkGate = rcQ;
    assign dmaGate = dgQ;

    // assertions; gates are checked on the outputs, not on the stored bits,
    // so a broken output register is caught as well as a broken decode

    // RULE1: set bit gates ref clock
    a_refclk_write_off: assert property ( // RULE1
        @(posedge clk) disable iff (sys_rst)
        wrStb && addr == `PMDB_OFS_REFC && wrData[`PMDB_BIT_REFO]
        |=> refClkGate.rstHold && !refClkGate.clkEn)
        else $error("ref clock not disabled");

    // RULE2: clear bit enables ref clock
    a_refclk_clear_on: assert property ( // RULE2
        @(posedge clk) disable iff (sys_rst)
        !refcQ[`PMDB_BIT_REFO]
        |-> refClkGate.clkEn && !refClkGate.rstHold)
        else $error("ref clock not enabled");

    // RULE2: clearing write enables ref clock
    a_refclk_write_on: assert property ( // RULE2
        @(posedge clk) disable iff (sys_rst)
        wrStb && addr == `PMDB_OFS_REFC && !wrData[`PMDB_BIT_REFO]
        |=> refClkGate.clkEn && !refClkGate.rstHold)
        else $error("ref clock not re-enabled");

    // RULE2: ref clock gate holds without write
    a_refclk_hold: assert property ( // RULE2
        @(posedge clk) disable iff (sys_rst)
        !(wrStb && addr == `PMDB_OFS_REFC)
        |=> $stable(refClkGate))
        else $error("ref clock gate changed without write");

    // RULE3: channel 3 at bit 11
    a_dma_ch3_off: assert property ( // RULE3
        @(posedge clk) disable iff (sys_rst)
        wrStb && addr == `PMDB_OFS_DMA
        |=> dmaGate[3].rstHold == $past(wrData[11]))
        else $error("dma channel 3 gate wrong");

    // RULE3: channel 2 at bit 10
    a_dma_ch2_off: assert property ( // RULE3
        @(posedge clk) disable iff (sys_rst)
        wrStb && addr == `PMDB_OFS_DMA
        |=> dmaGate[2].rstHold == $past(wrData[10]))
        else $error("dma channel 2 gate wrong");

    // RULE3: channel 1 at bit 9
    a_dma_ch1_off: assert property ( // RULE3
        @(posedge clk) disable iff (sys_rst)
        wrStb && addr == `PMDB_OFS_DMA
        |=> dmaGate[1].rstHold == $past(wrData[9]))
        else $error("dma channel 1 gate wrong");

    // RULE3: channel 0 at bit 8
    a_dma_ch0_off: assert property ( // RULE3
        @(posedge clk) disable iff (sys_rst)
        wrStb && addr == `PMDB_OFS_DMA
        |=> dmaGate[0].rstHold == $past(wrData[8]))
        else $error("dma channel 0 gate wrong");

    // RULE4: clear bit enables channel 0
    a_dma_ch0_on: assert property ( // RULE4
        @(posedge clk) disable iff (sys_rst)
        wrStb && addr == `PMDB_OFS_DMA && !wrData[8]
        |=> dmaGate[0].clkEn)
        else $error("dma channel 0 not enabled");

    // RULE4: dma gates hold without write
    a_dma_hold: assert property ( // RULE4
        @(posedge clk) disable iff (sys_rst)
        !(wrStb && addr == `PMDB_OFS_DMA)
        |=> $stable(dmaGate))
        else $error("dma gate changed without write");

    // RULE5: ref clock spare bits read zero
    a_unimpl_zero: assert property ( // RULE5
        @(posedge clk) disable iff (sys_rst)
        rdStb && addr == `PMDB_OFS_REFC
        |=> rdData[2:0] == 3'h0 && rdData[15:4] == 12'h000)
        else $error("unimplemented bits not zero");

    // RULE5: spare checksum bits stay zero
    a_crc_spare_zero: assert property ( // RULE5
        @(posedge clk) disable iff (sys_rst)
        (crcuQ & ~`PMDB_MASK_CRCU) == 16'h0000)
        else $error("checksum register spare bit set");

    // RULE5: spare dma bits stay zero
    a_dma_spare_zero: assert property ( // RULE5
        @(posedge clk) disable iff (sys_rst)
        (dmaQ & ~`PMDB_MASK_DMA) == 16'h0000)
        else $error("dma register spare bit set");

    // RULE5: spare ref clock bits stay zero
    a_refc_spare_zero: assert property ( // RULE5
        @(posedge clk) disable iff (sys_rst)
        (refcQ & ~`PMDB_MASK_REFC) == 16'h0000)
        else $error("ref clock register spare bit set");

    // RULE5: unmapped index reads zero
    a_unmapped_read: assert property ( // RULE5
        @(posedge clk) disable iff (sys_rst)
        rdStb && addr > `PMDB_OFS_DMA
        |=> rdData == 16'h0000)
        else $error("unmapped read not zero");

    // RULE5: no strobe, read data zero
    a_idle_read_zero: assert property ( // RULE5
        @(posedge clk) disable iff (sys_rst)
        !rdStb
        |=> rdData == 16'h0000)
        else $error("read data without strobe");

    // RULE6: checksum bit 7, serial bit 3
    a_crc_bit_off: assert property ( // RULE6
        @(posedge clk) disable iff (sys_rst)
        wrStb && addr == `PMDB_OFS_CRCU
        |=> checksumGate.rstHold == $past(wrData[7])
        && serial3Gate.rstHold == $past(wrData[3]))
        else $error("checksum or serial gate wrong");

    // RULE6: checksum gates hold without write
    a_crc_hold: assert property ( // RULE6
        @(posedge clk) disable iff (sys_rst)
        !(wrStb && addr == `PMDB_OFS_CRCU)
        |=> $stable(checksumGate) && $stable(serial3Gate))
        else $error("checksum gate changed without write");

    // RULE7: checksum clock and reset paired
    a_gate_pair: assert property ( // RULE7
        @(posedge clk) disable iff (sys_rst)
        checksumGate.clkEn != checksumGate.rstHold)
        else $error("gate pair inconsistent");

    // RULE7: serial and ref clock paired
    a_serial_ref_pair: assert property ( // RULE7
        @(posedge clk) disable iff (sys_rst)
        serial3Gate.clkEn != serial3Gate.rstHold
        && refClkGate.clkEn != refClkGate.rstHold)
        else $error("serial or ref clock pair inconsistent");

    // RULE7: dma channel 0 and 3 gates paired
    a_dma_pair: assert property ( // RULE7
        @(posedge clk) disable iff (sys_rst)
        dmaGate[0].clkEn != dmaGate[0].rstHold
        && dmaGate[3].clkEn != dmaGate[3].rstHold)
        else $error("dma pair inconsistent");

    // RULE3: back-to-back write then read
    a_read_back: assert property ( // RULE3
        @(posedge clk) disable iff (sys_rst)
        wrStb && addr == `PMDB_OFS_DMA ##1 rdStb && addr == `PMDB_OFS_DMA
        |=> rdData == ($past(wrData, 2) & `PMDB_MASK_DMA))
        else $error("dma readback wrong");
endmodule // pmdb_bank
`default_nettype wire

// ===== verif/tb_top.sv
`include "pmdb_cfg.svh"
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import pmdb_pkg::*;
    logic clk = 1'h0, sysRst = 1'h1, wrStb = 1'h0, rdStb = 1'h0;
    pmdb_addr_t addr = '0;
    pmdb_word_t wrData = '0, rdData;
    pmdb_gate_s csG, u3G, rcG;
    pmdb_gate_s [3:0] dmG;
    int nMismatch = 0, totalChecks = 0, cyc = 0;
    pmdb_bank dut (.clk(clk), .sys_rst(sysRst), .addr(addr),
        .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData),
        .checksumGate(csG), .serial3Gate(u3G), .refClkGate(rcG),
        .dmaGate(dmG));
    // free-running system clock
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            nMismatch++;
            $display("unexpected at %0t: %h vs %h", $time, seen, exp);
        end
    endtask
    // strobe one cycle, then let the write edge land
    task automatic wr(input pmdb_addr_t a, input pmdb_word_t d);
        @(posedge clk);
        addr <= a;
        wrData <= d;
        wrStb <= 1'h1;
        @(posedge clk);
        wrStb <= 1'h0;
        #1;
    endtask
    // read data is only valid in the cycle after the strobe edge
    task automatic rd(input pmdb_addr_t a, input pmdb_word_t e);
        @(posedge clk);
        addr <= a;
        rdStb <= 1'h1;
        @(posedge clk);
        rdStb <= 1'h0;
        #1 chk(rdData, e);
    endtask
    // dis bits: checksum, serial3, refclk, dma3..dma0; set means gated off
    task automatic gates(input logic [6:0] dis);
        logic [15:0] e;
        e = '0;
        for (int i = 0; i < 7; i++) e[2*i +: 2] = {~dis[i], dis[i]};
        chk({2'h0, csG, u3G, rcG, dmG}, e);
    endtask
    task automatic t_ones;
        rd(`PMDB_OFS_CRCU, 16'h0000);
        rd(`PMDB_OFS_REFC, 16'h0000);
        rd(`PMDB_OFS_DMA, 16'h0000);
        gates(7'h00);
        wr(`PMDB_OFS_CRCU, 16'hFFFF);
        wr(`PMDB_OFS_REFC, 16'hFFFF);
        wr(`PMDB_OFS_DMA, 16'hFFFF);
        gates(7'h7F);
        rd(`PMDB_OFS_CRCU, 16'h0088);
        rd(`PMDB_OFS_REFC, 16'h0008);
        rd(`PMDB_OFS_DMA, 16'h0F00);
        wr(4'h3, 16'hFFFF);
        rd(4'h3, 16'h0000);
        gates(7'h7F);
        $display("reset and all-ones test done");
    endtask
    task automatic t_single;
        wr(`PMDB_OFS_CRCU, 16'h0000);
        wr(`PMDB_OFS_REFC, 16'h0000);
        wr(`PMDB_OFS_DMA, 16'h0000);
        gates(7'h00);
        for (int c = 0; c < 4; c++) begin
            wr(`PMDB_OFS_DMA, 16'h0100 << c);
            gates(7'h01 << c);
            rd(`PMDB_OFS_DMA, 16'h0100 << c);
        end
        wr(`PMDB_OFS_DMA, 16'h0000);
        wr(`PMDB_OFS_CRCU, 16'h0080);
        gates(7'h40);
        wr(`PMDB_OFS_CRCU, 16'h0008);
        gates(7'h20);
        wr(`PMDB_OFS_REFC, 16'h0008);
        gates(7'h30);
        wr(`PMDB_OFS_REFC, 16'hFFF7);
        gates(7'h20);
        $display("single-bit test done");
    endtask
    // back-to-back write and read, then a reset in mid-run
    task automatic t_reset;
        @(posedge clk);
        addr <= `PMDB_OFS_DMA;
        wrData <= 16'h0500;
        wrStb <= 1'h1;
        @(posedge clk);
        wrStb <= 1'h0;
        rdStb <= 1'h1;
        @(posedge clk);
        rdStb <= 1'h0;
        #1 chk(rdData, 16'h0500);
        @(posedge clk);
        #1 chk(rdData, 16'h0000);
        wr(`PMDB_OFS_CRCU, 16'hFFFF);
        wr(`PMDB_OFS_REFC, 16'hFFFF);
        @(posedge clk);
        sysRst <= 1'h1;
        @(posedge clk);
        #1 gates(7'h00);
        @(posedge clk);
        sysRst <= 1'h0;
        rd(`PMDB_OFS_DMA, 16'h0000);
        rd(`PMDB_OFS_REFC, 16'h0000);
        gates(7'h00);
        $display("mid-run reset test done");
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", totalChecks, nMismatch);
        if (nMismatch == 0 && totalChecks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // hang guard: the whole run needs well under 200 cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            nMismatch++;
            end_sim();
        end
    end
    initial begin
        repeat (2) @(posedge clk);
        sysRst <= 1'h0;
        t_ones();
        t_single();
        t_reset();
        end_sim();
    end
endmodule // tb_top
`default_nettype wire
